// ---- verilog/qsc_pkg.sv ----
`default_nettype none
package qsc_pkg;
    localparam int QSC_BANKS   = 4;
    localparam int QSC_ROWS    = 2048;
    localparam int QSC_COLS    = 256;
    localparam int QSC_WORDS   = QSC_BANKS * QSC_ROWS * QSC_COLS;
    localparam int QSC_BA_W    = 2;
    localparam int QSC_ROW_W   = 11;
    localparam int QSC_COL_W   = 8;
    localparam int QSC_DQ_W    = 32;
    localparam int QSC_LANES   = 4;
    localparam int QSC_LANE_W  = 8;
    localparam int QSC_AP_BIT  = 10;
    localparam int QSC_PIPE    = 3;

    // Mode word carried on the address lines
    localparam int QSC_MR_BL_LSB = 0;
    localparam int QSC_MR_BL_W   = 3;
    localparam int QSC_MR_BT_BIT = 3;
    localparam int QSC_MR_CL_LSB = 4;
    localparam int QSC_MR_CL_W   = 3;
    localparam int QSC_MR_WB_BIT = 9;
    localparam logic [10:0] QSC_MR_RESET = 11'h020;
    localparam logic [2:0] QSC_BL_1    = 3'h0;
    localparam logic [2:0] QSC_BL_2    = 3'h1;
    localparam logic [2:0] QSC_BL_4    = 3'h2;
    localparam logic [2:0] QSC_BL_8    = 3'h3;
    localparam logic [2:0] QSC_BL_FULL = 3'h7;
    localparam logic [2:0] QSC_CL_3    = 3'h3;
    localparam logic [7:0] QSC_COL_ALL = 8'hff;

    // Refresh budget: 4096 refreshes per 64 ms, or per 16 ms for hot parts
    localparam int QSC_REF_CYCLES   = 4096;
    localparam int QSC_REF_WIN_MS   = 64;
    localparam int QSC_REF_HOT_MS   = 16;
    localparam int QSC_CLK_NS       = 10;
    localparam int QSC_REF_GAP      =
        QSC_REF_WIN_MS * 1000000 / QSC_REF_CYCLES / QSC_CLK_NS;
    localparam int QSC_REF_GAP_HOT  =
        QSC_REF_HOT_MS * 1000000 / QSC_REF_CYCLES / QSC_CLK_NS;

    // Controller registers on AXI4-Lite
    localparam logic [4:0] QSC_REG_CMD   = 5'h00;
    localparam logic [4:0] QSC_REG_WDATA = 5'h04;
    localparam logic [4:0] QSC_REG_CTRL  = 5'h08;
    localparam logic [4:0] QSC_REG_RDATA = 5'h0c;
    localparam logic [4:0] QSC_REG_STAT  = 5'h10;
    localparam int QSC_CMD_OP_LSB   = 0;
    localparam int QSC_CMD_BA_LSB   = 4;
    localparam int QSC_CMD_ADDR_LSB = 16;
    localparam int QSC_CTRL_CKE_BIT = 0;
    localparam int QSC_CTRL_DQM_LSB = 4;
    localparam logic [31:0] QSC_CTRL_RESET = 32'h0000_0001;
    localparam int QSC_STAT_DUE_BIT = 31;
    localparam logic [1:0] QSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] QSC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_ACT = 3'b001,
        CMD_RD  = 3'b010,
        CMD_WR  = 3'b011,
        CMD_BST = 3'b100,
        CMD_PRE = 3'b101,
        CMD_REF = 3'b110,
        CMD_MRS = 3'b111
    } qsc_cmd_type;

    typedef enum logic [1:0] {
        BURST_IDLE  = 2'b00,
        BURST_READ  = 2'b01,
        BURST_WRITE = 2'b10
    } qsc_burst_type;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_DOWN   = 2'b01,
        PWR_SELF   = 2'b10
    } qsc_pwr_type;

    // Strobe levels {ras_n, cas_n, we_n} for each command
    function automatic logic [2:0] qsc_encode(input qsc_cmd_type c);
        case (c)
            CMD_ACT: qsc_encode = 3'b011;
            CMD_RD:  qsc_encode = 3'b101;
            CMD_WR:  qsc_encode = 3'b100;
            CMD_BST: qsc_encode = 3'b110;
            CMD_PRE: qsc_encode = 3'b010;
            CMD_REF: qsc_encode = 3'b001;
            CMD_MRS: qsc_encode = 3'b000;
            default: qsc_encode = 3'b111;
        endcase
    endfunction

    function automatic qsc_cmd_type qsc_decode(input logic cs_n,
                                               input logic [2:0] rcw);
        qsc_decode = CMD_NOP;
        if (!cs_n)
        begin
            case (rcw)
                3'b011:  qsc_decode = CMD_ACT;
                3'b101:  qsc_decode = CMD_RD;
                3'b100:  qsc_decode = CMD_WR;
                3'b110:  qsc_decode = CMD_BST;
                3'b010:  qsc_decode = CMD_PRE;
                3'b001:  qsc_decode = CMD_REF;
                3'b000:  qsc_decode = CMD_MRS;
                default: qsc_decode = CMD_NOP;
            endcase
        end
    endfunction
endpackage
`default_nettype wire

// ---- verilog/qsc_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface qsc_link_if;
    import qsc_pkg::*;
    logic                  cke;
    logic                  cs_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic [QSC_BA_W-1:0]   bank_select_bits;
    logic [QSC_ROW_W-1:0]  addr;
    logic [QSC_LANES-1:0]  byte_lane_masks;
    logic [QSC_DQ_W-1:0]   dq_ctl_o;
    logic                  dq_ctl_oe_n;
    logic [QSC_DQ_W-1:0]   dq_dev_o;
    logic [QSC_LANES-1:0]  dq_dev_oe_n;
    wire  [QSC_DQ_W-1:0]   dq;

    // Resolved data bus level, one byte lane at a time
    for (genvar g = 0; g < QSC_LANES; g++)
    begin : g_lane
        assign dq[g*QSC_LANE_W +: QSC_LANE_W] =
            !dq_ctl_oe_n    ? dq_ctl_o[g*QSC_LANE_W +: QSC_LANE_W] :
            !dq_dev_oe_n[g] ? dq_dev_o[g*QSC_LANE_W +: QSC_LANE_W] :
                              {QSC_LANE_W{1'b1}}; // Idle lane reads high
    end

    modport dev (
        input  cke, cs_n, ras_n, cas_n, we_n, bank_select_bits, addr,
               byte_lane_masks, dq,
        output dq_dev_o, dq_dev_oe_n
    );
    modport ctl (
        output cke, cs_n, ras_n, cas_n, we_n, bank_select_bits, addr,
               byte_lane_masks, dq_ctl_o, dq_ctl_oe_n,
        input  dq, dq_dev_oe_n
    );
endinterface
`default_nettype wire

// ---- verilog/qsc_sdram_dev.sv ----
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module qsc_sdram_dev
    import qsc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    qsc_link_if.dev          link,
    output logic [1:0]       power_state,
    output logic [15:0]      refresh_count,
    output logic [3:0]       open_banks
);
    logic [QSC_DQ_W-1:0]  store [0:QSC_WORDS-1];
    logic [QSC_ROW_W-1:0] row_q [QSC_BANKS];
    logic [QSC_BANKS-1:0] open_q;
    logic [10:0]          mode_q;
    qsc_pwr_type          pwr_q;
    logic [15:0]          ref_cnt_q;
    qsc_burst_type        bst_q;
    logic [QSC_BA_W-1:0]  bbank_q;
    logic [QSC_COL_W-1:0] bstart_q;
    logic [QSC_COL_W-1:0] bidx_q;
    logic                 bap_q;
    logic                 pv_q [QSC_PIPE];
    logic [QSC_DQ_W-1:0]  pd_q [QSC_PIPE];
    logic [QSC_LANES-1:0] pm_q [QSC_PIPE];

    qsc_cmd_type          cmd;
    logic                 ck;
    logic                 new_acc;
    logic                 stop;
    logic                 cur_act;
    logic                 cur_wr;
    logic                 cur_ap;
    logic                 cur_last;
    logic [QSC_BA_W-1:0]  cur_bank;
    logic [QSC_COL_W-1:0] cur_start;
    logic [QSC_COL_W-1:0] cur_idx;
    logic [QSC_COL_W-1:0] cur_mask;
    logic [QSC_COL_W-1:0] cur_col;
    logic [20:0]          word_addr;
    logic [QSC_MR_BL_W-1:0] bl_code;
    logic                 full_page;
    int                   lat;

    // Column span of one burst, as an address mask
    function automatic logic [QSC_COL_W-1:0] burst_mask(
        input logic [QSC_MR_BL_W-1:0] code);
        case (code)
            QSC_BL_1:    burst_mask = 8'h00;
            QSC_BL_2:    burst_mask = 8'h01;
            QSC_BL_4:    burst_mask = 8'h03;
            QSC_BL_8:    burst_mask = 8'h07;
            default:     burst_mask = QSC_COL_ALL;
        endcase
    endfunction

    assign ck  = link.cke;
    assign cmd = qsc_decode(link.cs_n,
                            {link.ras_n, link.cas_n, link.we_n});
    assign bl_code   = mode_q[QSC_MR_BL_LSB +: QSC_MR_BL_W];
    assign full_page = (bl_code == QSC_BL_FULL);
    assign lat = (mode_q[QSC_MR_CL_LSB +: QSC_MR_CL_W] == QSC_CL_3)
                 ? QSC_PIPE - 1 : QSC_PIPE - 2;

    // Read or write to an open bank starts a fresh burst at once
    assign new_acc = ck && (cmd == CMD_RD || cmd == CMD_WR)
                     && open_q[link.bank_select_bits];
    assign stop = ck && (cmd == CMD_BST || (cmd == CMD_PRE
                  && (link.addr[QSC_AP_BIT]
                  || link.bank_select_bits == bbank_q)));

    always_comb
    begin
        cur_wr    = (bst_q == BURST_WRITE);
        cur_bank  = bbank_q;
        cur_start = bstart_q;
        cur_idx   = bidx_q;
        cur_ap    = bap_q;
        cur_act   = ck && (bst_q != BURST_IDLE) && !stop;
        if (new_acc)
        begin
            cur_wr    = (cmd == CMD_WR);
            cur_bank  = link.bank_select_bits;
            cur_start = link.addr[QSC_COL_W-1:0];
            cur_idx   = '0;
            cur_ap    = link.addr[QSC_AP_BIT];
            cur_act   = 1'b1;
        end
        cur_mask = burst_mask(bl_code);
        if (cur_wr && mode_q[QSC_MR_WB_BIT])
        begin
            cur_mask = '0;
        end
        if (mode_q[QSC_MR_BT_BIT] && !full_page)
        begin
            cur_col = (cur_start & ~cur_mask)
                      | ((cur_start ^ cur_idx) & cur_mask);
        end
        else
        begin
            cur_col = (cur_start & ~cur_mask)
                      | ((cur_start + cur_idx) & cur_mask);
        end
        cur_last = (cur_idx == cur_mask);
        if (full_page && !(cur_wr && mode_q[QSC_MR_WB_BIT]))
        begin
            cur_last = 1'b0;
        end
        word_addr = {cur_bank, row_q[cur_bank], cur_col};
    end

    // Burst sequencing
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            bst_q    <= BURST_IDLE;
            bbank_q  <= '0;
            bstart_q <= '0;
            bidx_q   <= '0;
            bap_q    <= 1'b0;
        end
        else if (ck)
        begin
            if (cur_act && !cur_last)
            begin
                bst_q    <= cur_wr ? BURST_WRITE : BURST_READ;
                bbank_q  <= cur_bank;
                bstart_q <= cur_start;
                bidx_q   <= cur_idx + 8'h01;
                bap_q    <= cur_ap;
            end
            else
            begin
                bst_q <= BURST_IDLE;
            end
        end
    end

    // Row state per bank
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            open_q <= '0;
            for (int b = 0; b < QSC_BANKS; b++)
            begin
                row_q[b] <= '0;
            end
        end
        else if (ck)
        begin
            for (int b = 0; b < QSC_BANKS; b++)
            begin
                if (cur_act && cur_last && cur_ap && cur_bank == b)
                begin
                    open_q[b] <= 1'b0;
                end
                if (cmd == CMD_PRE && (link.addr[QSC_AP_BIT]
                    || link.bank_select_bits == b))
                begin
                    open_q[b] <= 1'b0;
                end
                if (cmd == CMD_ACT && link.bank_select_bits == b)
                begin
                    open_q[b] <= 1'b1;
                    row_q[b]  <= link.addr;
                end
            end
        end
    end

    // Mode word, refresh tally and low-power state
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mode_q    <= QSC_MR_RESET;
            ref_cnt_q <= '0;
            pwr_q     <= PWR_ACTIVE;
        end
        else
        begin
            if (ck && cmd == CMD_MRS && bst_q == BURST_IDLE)
            begin
                mode_q <= link.addr;
            end
            if (cmd == CMD_REF && (ck || pwr_q == PWR_ACTIVE))
            begin
                ref_cnt_q <= ref_cnt_q + 16'h0001;
            end
            if (ck)
            begin
                pwr_q <= PWR_ACTIVE;
            end
            else if (pwr_q == PWR_ACTIVE)
            begin
                pwr_q <= (cmd == CMD_REF) ? PWR_SELF : PWR_DOWN;
            end
        end
    end

    // Write lanes land in the array unless masked
    // One process owns the array; lanes are picked inside it
    always_ff @(posedge core_clk)
    begin
        for (int g = 0; g < QSC_LANES; g++)
        begin
            if (ck && cur_act && cur_wr && !link.byte_lane_masks[g])
            begin
                store[word_addr][g*QSC_LANE_W +: QSC_LANE_W] <=
                    link.dq[g*QSC_LANE_W +: QSC_LANE_W];
            end
        end
    end

    // Read pipeline: entry k is driven k+1 edges after its fetch
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < QSC_PIPE; k++)
            begin
                pv_q[k] <= 1'b0;
                pd_q[k] <= '0;
                pm_q[k] <= '0;
            end
        end
        else if (ck)
        begin
            pv_q[0] <= cur_act && !cur_wr;
            pd_q[0] <= store[word_addr];
            pm_q[0] <= link.byte_lane_masks;
            for (int k = 1; k < QSC_PIPE; k++)
            begin
                pv_q[k] <= pv_q[k-1];
                pd_q[k] <= pd_q[k-1];
                pm_q[k] <= pm_q[k-1];
            end
        end
    end

    assign link.dq_dev_o = pd_q[lat];
    for (genvar g = 0; g < QSC_LANES; g++)
    begin : g_oe
        assign link.dq_dev_oe_n[g] = !(pv_q[lat] && !pm_q[lat][g]);
    end

    assign power_state   = pwr_q;
    assign refresh_count = ref_cnt_q;
    assign open_banks    = open_q;
endmodule // qsc_sdram_dev
`default_nettype wire

// ---- verilog/qsc_sdram_ctl.sv ----
`timescale 1ns/1ps
`default_nettype none
module qsc_sdram_ctl
    import qsc_pkg::*;
#(
    parameter bit HOT_GRADE = 1'b0
)
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    qsc_link_if.ctl          link,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int GAP = HOT_GRADE ? QSC_REF_GAP_HOT : QSC_REF_GAP;

    logic        aw_got_q;
    logic [4:0]  awaddr_q;
    logic        w_got_q;
    logic [31:0] wd_q;
    logic [31:0] ctrl_q;
    logic [31:0] wdata_q;
    logic [31:0] rdata_q;
    logic [15:0] rcnt_q;
    logic        due_q;
    logic [11:0] gap_q;
    logic        do_wr;
    logic        issue;
    qsc_cmd_type op;

    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr = aw_got_q && w_got_q;
    assign issue = do_wr && awaddr_q == QSC_REG_CMD;
    assign op    = qsc_cmd_type'(wd_q[QSC_CMD_OP_LSB +: 3]);

    // Write side: address and data taken in either order
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            aw_got_q     <= 1'b0;
            awaddr_q     <= '0;
            w_got_q      <= 1'b0;
            wd_q         <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= QSC_RESP_OKAY;
            ctrl_q       <= QSC_CTRL_RESET;
            wdata_q      <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wd_q    <= s_axi_wdata;
            end
            if (do_wr)
            begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= QSC_RESP_OKAY;
                case (awaddr_q)
                    QSC_REG_CMD:   ;
                    QSC_REG_WDATA: wdata_q <= wd_q;
                    QSC_REG_CTRL:  ctrl_q  <= wd_q;
                    default:       s_axi_bresp <= QSC_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read side: one cycle to answer
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= QSC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= QSC_RESP_OKAY;
            case (s_axi_araddr)
                QSC_REG_WDATA: s_axi_rdata <= wdata_q;
                QSC_REG_CTRL:  s_axi_rdata <= ctrl_q;
                QSC_REG_RDATA: s_axi_rdata <= rdata_q;
                QSC_REG_STAT:  s_axi_rdata <= {due_q, 15'h0000, rcnt_q};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= QSC_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // One command on the link for one cycle per command-register write
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            {link.ras_n, link.cas_n, link.we_n} <= qsc_encode(CMD_NOP);
            link.cs_n             <= 1'b1;
            link.bank_select_bits <= '0;
            link.addr             <= '0;
            link.dq_ctl_o         <= '0;
            link.dq_ctl_oe_n      <= 1'b1;
        end
        else
        begin
            link.cs_n <= !issue;
            {link.ras_n, link.cas_n, link.we_n} <=
                issue ? qsc_encode(op) : qsc_encode(CMD_NOP);
            link.dq_ctl_oe_n <= !(issue && op == CMD_WR);
            if (issue)
            begin
                link.bank_select_bits <= wd_q[QSC_CMD_BA_LSB +: QSC_BA_W];
                link.addr     <= wd_q[QSC_CMD_ADDR_LSB +: QSC_ROW_W];
                link.dq_ctl_o <= wdata_q;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            link.cke             <= 1'b1;
            link.byte_lane_masks <= '0;
        end
        else
        begin
            link.cke <= ctrl_q[QSC_CTRL_CKE_BIT];
            link.byte_lane_masks <=
                ctrl_q[QSC_CTRL_DQM_LSB +: QSC_LANES];
        end
    end

    // Capture read words lane by lane as the memory drives them
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rdata_q <= '0;
            rcnt_q  <= '0;
        end
        else
        begin
            for (int g = 0; g < QSC_LANES; g++)
            begin
                if (!link.dq_dev_oe_n[g])
                begin
                    rdata_q[g*QSC_LANE_W +: QSC_LANE_W] <=
                        link.dq[g*QSC_LANE_W +: QSC_LANE_W];
                end
            end
            if (!(&link.dq_dev_oe_n))
            begin
                rcnt_q <= rcnt_q + 16'h0001;
            end
        end
    end

    // Refresh-due flag: interval elapsing wins over a refresh issued
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            gap_q <= '0;
            due_q <= 1'b0;
        end
        else
        begin
            if (gap_q == 12'(GAP - 1))
            begin
                gap_q <= '0;
                due_q <= 1'b1;
            end
            else
            begin
                gap_q <= gap_q + 12'h001;
                if (issue && op == CMD_REF)
                begin
                    due_q <= 1'b0;
                end
            end
        end
    end
endmodule // qsc_sdram_ctl
`default_nettype wire

// ---- tb/qsc_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module qsc_link_checker
(
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       cke,
    input wire logic       cs_n,
    input wire logic       ras_n,
    input wire logic       cas_n,
    input wire logic       we_n,
    input wire logic [10:0] addr,
    input wire logic [3:0] byte_lane_masks,
    input wire logic       dq_ctl_oe_n,
    input wire logic [3:0] dq_dev_oe_n
);
    logic rd;
    logic wr;
    assign rd = cke && !cs_n && {ras_n, cas_n, we_n} == 3'b101;
    assign wr = cke && !cs_n && {ras_n, cas_n, we_n} == 3'b100;
    logic cl3_q;
    // Tracks the read latency loaded by a mode-word command
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cl3_q <= 1'b0;
        end
        else if (cke && !cs_n && {ras_n, cas_n, we_n} == 3'b000)
        begin
            cl3_q <= (addr[6:4] == 3'h3);
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    a_reset_idle: assert property ($past(sys_rst) |-> cs_n && cke
        && dq_ctl_oe_n && dq_dev_oe_n == 4'hf) else $error("busy at reset");
    a_wr_drives: assert property (wr |-> !dq_ctl_oe_n)
        else $error("write without data");
    a_ctl_quiet: assert property (!dq_ctl_oe_n |-> wr)
        else $error("data without write");
    a_no_fight: assert property (!dq_ctl_oe_n |-> dq_dev_oe_n == 4'hf)
        else $error("both ends drive");
    a_cmd_single: assert property (!cs_n |=> cs_n)
        else $error("command held");
    a_read_lat: assert property (dq_dev_oe_n != 4'hf
        |-> (cl3_q ? $past(rd, 3) : $past(rd, 2)))
        else $error("read data off time");
    a_cke_freeze: assert property (!cke |=> $stable(dq_dev_oe_n))
        else $error("moved while gated");
    a_lane_mask: assert property (dq_dev_oe_n != 4'hf
        |-> dq_dev_oe_n == byte_lane_masks) else $error("mask ignored");
    c_read: cover property (rd);
    c_write: cover property (wr);
    c_gate: cover property (!cke);
endmodule // qsc_link_checker
`default_nettype wire

// ---- tb/quad_bank_sdram_command_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module quad_bank_sdram_command_core_tb;
    import qsc_pkg::*;
    logic        core_clk = 0;
    logic        sys_rst = 1;
    logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    logic [31:0] d[4];
    logic [31:0] m;
    logic [7:0]  col;
    logic [1:0]  pwr;
    logic [15:0] nref;
    logic [3:0]  obank;
    int          n_mismatch = 0, checked = 0, cyc = 0;
    qsc_link_if link_if ();
    qsc_sdram_dev qsc_sdram_dev_inst (.core_clk, .sys_rst, .link(link_if),
        .power_state(pwr), .refresh_count(nref), .open_banks(obank));
    qsc_sdram_ctl qsc_sdram_ctl_inst (.core_clk, .sys_rst, .link(link_if),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    qsc_link_checker qsc_link_checker_inst (.core_clk, .sys_rst,
        .cke(link_if.cke), .cs_n(link_if.cs_n), .ras_n(link_if.ras_n),
        .cas_n(link_if.cas_n), .we_n(link_if.we_n), .addr(link_if.addr),
        .byte_lane_masks(link_if.byte_lane_masks),
        .dq_ctl_oe_n(link_if.dq_ctl_oe_n), .dq_dev_oe_n(link_if.dq_dev_oe_n));
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] cw(qsc_cmd_type op, logic [1:0] b,
                                       logic [10:0] a);
        return {5'h0, a, 10'h0, b, 1'h0, op};
    endfunction
    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic summarize();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] v, logic [1:0] r = 0);
        logic ta;
        logic tw;
        ta = 0;
        tw = 0;
        @(posedge core_clk);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw))
        begin
            @(posedge core_clk);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        do @(posedge core_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [33:0] e);
        repeat (6) @(posedge core_clk);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (s_axi_bvalid && s_axi_bready)
            cmp({32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready)
            cmp(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (cyc == 5000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    initial
    begin
        void'($urandom(32'h69d387e7));
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(QSC_REG_CTRL, {QSC_RESP_OKAY, QSC_CTRL_RESET});
        wr(5'h14, 32'h0, QSC_RESP_SLVERR);
        rd(5'h1c, {QSC_RESP_SLVERR, 32'h0});
        col = 8'($urandom);
        for (int b = 0; b < 4; b++)
        begin
            d[b] = $urandom;
            wr(QSC_REG_WDATA, d[b]);
            wr(QSC_REG_CMD, cw(CMD_ACT, b[1:0], 11'($urandom)));
            wr(QSC_REG_CMD, cw(CMD_WR, b[1:0], {3'h0, col}));
        end
        for (int b = 0; b < 4; b++)
        begin
            wr(QSC_REG_CMD, cw(CMD_RD, b[1:0], {3'h0, col}));
            rd(QSC_REG_RDATA, {QSC_RESP_OKAY, d[b]});
        end
        wr(QSC_REG_CTRL, 32'h31);
        wr(QSC_REG_WDATA, ~d[0]);
        wr(QSC_REG_CMD, cw(CMD_WR, 2'h0, {3'h0, col}));
        wr(QSC_REG_CTRL, 32'h1);
        wr(QSC_REG_CMD, cw(CMD_RD, 2'h0, {3'h0, col}));
        m = {~d[0][31:16], d[0][15:0]};
        rd(QSC_REG_RDATA, {QSC_RESP_OKAY, m});
        wr(QSC_REG_CTRL, 32'hc1);
        wr(QSC_REG_CMD, cw(CMD_RD, 2'h1, {3'h0, col}));
        rd(QSC_REG_RDATA, {QSC_RESP_OKAY, m[31:16], d[1][15:0]});
        wr(QSC_REG_CTRL, 32'h1);
        wr(QSC_REG_CMD, cw(CMD_RD, 2'h2, {3'h4, col}));
        rd(QSC_REG_RDATA, {QSC_RESP_OKAY, d[2]});
        wr(QSC_REG_CMD, cw(CMD_RD, 2'h3, {3'h0, col}));
        wr(QSC_REG_CMD, cw(CMD_RD, 2'h2, {3'h0, col}));
        rd(QSC_REG_RDATA, {QSC_RESP_OKAY, d[3]});
        wr(QSC_REG_CMD, cw(CMD_PRE, 2'h0, 11'h400));
        wr(QSC_REG_CMD, cw(CMD_RD, 2'h1, {3'h0, col}));
        rd(QSC_REG_RDATA, {QSC_RESP_OKAY, d[3]});
        cmp(34'h0, {30'h0, obank});
        wr(QSC_REG_CMD, cw(CMD_MRS, 2'h0, 11'h030));
        wr(QSC_REG_CMD, cw(CMD_ACT, 2'h1, 11'h7ff));
        wr(QSC_REG_CMD, cw(CMD_WR, 2'h1, {3'h0, col}));
        wr(QSC_REG_CMD, cw(CMD_RD, 2'h1, {3'h0, col}));
        rd(QSC_REG_RDATA, {QSC_RESP_OKAY, ~d[0]});
        cmp(34'h2, {30'h0, obank});
        wr(QSC_REG_CTRL, 32'h0);
        rd(QSC_REG_CTRL, {QSC_RESP_OKAY, 32'h0});
        cmp({32'h0, PWR_DOWN}, {32'h0, pwr});
        wr(QSC_REG_CTRL, 32'h1);
        repeat (QSC_REF_GAP) @(posedge core_clk);
        rd(QSC_REG_STAT, {QSC_RESP_OKAY, 1'b1, 15'h0, 16'h0009});
        wr(QSC_REG_CMD, cw(CMD_REF, 2'h0, 11'h0));
        rd(QSC_REG_STAT, {QSC_RESP_OKAY, 1'b0, 15'h0, 16'h0009});
        cmp(34'h1, {18'h0, nref});
        summarize();
    end
endmodule // quad_bank_sdram_command_core_tb
`default_nettype wire
